// ### rtl/adcsd_serial_out.sv
`timescale 1ns/100ps
`include "adcsd_regs.svh"
module adcsd_serial_out (
  input  wire logic        clk_sys,              // System clock, 25 MHz
  input  wire logic        reset,                // Synchronous reset, active high
  input  wire logic [12:0] raw_result,           // Signed conversion result, may exceed range
  input  wire logic        result_load,          // Pulse: new conversion result ready
  input  wire logic        chip_select_n,        // Chip select, active low (pin)
  input  wire logic        read_convert,         // High selects read (pin)
  input  wire logic        clock_source_select,  // High: external shift clock (pin)
  input  wire logic        shift_clock_in,       // External shift clock (pin)
  input  wire logic        chain_in,             // Daisy-chain input (pin)
  output logic             shift_clock_out,      // Internal shift clock driven out
  output logic             shift_clock_oe_n,     // Low while shift clock is driven
  output logic             serial_result_pin,    // Serial result output
  output logic             serial_result_oe_n    // Low while serial output is driven
);
  adcsd_edge_if sck_ev ();
  adcsd_edge_if cs_ev ();
  adcsd_edge_if rc_ev ();
  adcsd_edge_if tag_ev ();
  adcsd_edge_if ext_ev ();

  adcsd_sync u_sck (.clk_sys(clk_sys), .reset(reset), .pin(shift_clock_in), .ev(sck_ev.src));
  adcsd_sync u_cs (.clk_sys(clk_sys), .reset(reset), .pin(chip_select_n), .ev(cs_ev.src));
  adcsd_sync u_rc (.clk_sys(clk_sys), .reset(reset), .pin(read_convert), .ev(rc_ev.src));
  adcsd_sync u_tag (.clk_sys(clk_sys), .reset(reset), .pin(chain_in), .ev(tag_ev.src));
  adcsd_sync u_ext (.clk_sys(clk_sys), .reset(reset), .pin(clock_source_select), .ev(ext_ev.src));

  adcsd_pkg::adcsd_state_t state_q;
  adcsd_pkg::adcsd_state_t state_d;
  logic [11:0] shreg_q;
  logic [11:0] shreg_d;
  logic [11:0] clamp_code;
  logic        pass_q;
  logic        pass_d;
  logic        dout_q;
  logic        dout_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic [7:0]  div_q;
  logic        iclk_q;
  logic        enabled;
  logic        ext_mode;
  logic        int_fall;
  logic        step;
  logic        start_rd;

  function automatic logic [11:0] adcsd_clamp(input logic [12:0] v);
    if (!v[12] && v[11])
      adcsd_clamp = `ADCSD_CODE_MAX;
    else if (v[12] && !v[11])
      adcsd_clamp = `ADCSD_CODE_MIN;
    else
      adcsd_clamp = {~v[11], v[10:0]};
  endfunction

  assign clamp_code = adcsd_clamp(raw_result);                       // see RULE_11
  assign enabled    = ~cs_ev.level & rc_ev.level;                    // see RULE_12
  assign ext_mode   = ext_ev.level;
  assign int_fall   = (div_q == 8'(`ADCSD_INT_HALF - 1)) & iclk_q;
  assign step       = enabled & (ext_mode ? sck_ev.fall : int_fall); // see RULE_03
  assign start_rd   = (state_q == adcsd_pkg::ADCSD_IDLE) & step;

  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    pass_d  = pass_q;
    dout_d  = dout_q;
    cnt_d   = cnt_q;
    if (result_load) begin
      shreg_d = clamp_code;
      state_d = adcsd_pkg::ADCSD_IDLE;
      cnt_d   = 4'h0;
    end else if (step) begin
      unique case (state_q)
        adcsd_pkg::ADCSD_IDLE: begin
          pass_d  = tag_ev.level;                                    // see RULE_07
          dout_d  = shreg_q[11];                                     // see RULE_13
          shreg_d = {shreg_q[10:0], tag_ev.level};                   // see RULE_14
          cnt_d   = 4'h1;
          state_d = adcsd_pkg::ADCSD_SHIFT;
        end
        adcsd_pkg::ADCSD_SHIFT: begin
          dout_d  = shreg_q[11];
          shreg_d = {shreg_q[10:0], tag_ev.level};                   // see RULE_14
          cnt_d   = cnt_q + 4'h1;
          if (cnt_q == 4'(`ADCSD_RES_BITS - 1))
            state_d = adcsd_pkg::ADCSD_PASS;
        end
        adcsd_pkg::ADCSD_PASS: begin
          // Ext: chained bits ripple; int: hold sampled level     see RULE_08
          dout_d  = ext_mode ? shreg_q[11] : pass_q;                 // see RULE_09 see RULE_10
          shreg_d = {shreg_q[10:0], tag_ev.level};
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= adcsd_pkg::ADCSD_IDLE;
      shreg_q <= 12'h000;
      pass_q  <= 1'b0;
      dout_q  <= 1'b0;
      cnt_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      pass_q  <= pass_d;
      dout_q  <= dout_d;
      cnt_q   <= cnt_d;
    end
  end

  // Internal shift clock divider, runs only while reading in internal mode
  always_ff @(posedge clk_sys) begin
    if (reset || ext_mode || !enabled) begin
      div_q  <= 8'h00;
      iclk_q <= 1'b0;
    end else if (div_q == 8'(`ADCSD_INT_HALF - 1)) begin
      div_q  <= 8'h00;
      iclk_q <= ~iclk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign shift_clock_out    = iclk_q;
  assign shift_clock_oe_n   = ext_mode | ~enabled;
  assign serial_result_pin  = (state_q == adcsd_pkg::ADCSD_IDLE) ? shreg_q[11] : dout_q;
  assign serial_result_oe_n = ~enabled;                              // see RULE_12

  // Pin conditions need five stable samples to pass the synchronisers
  sequence s_read_start;
    start_rd && !result_load;
  endsequence

  sequence s_last_bit;
    step && !result_load && state_q == adcsd_pkg::ADCSD_SHIFT && cnt_q == 4'(`ADCSD_RES_BITS - 1);
  endsequence

  a_out_enable: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_12
    (!chip_select_n && read_convert) [*5]
    |-> !serial_result_oe_n)
    else $error("serial output not enabled");

  a_out_off_cs: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_12
    chip_select_n [*5]
    |-> serial_result_oe_n)
    else $error("serial output enabled while deselected");

  a_out_off_rc: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_12
    !read_convert [*5]
    |-> serial_result_oe_n)
    else $error("serial output enabled while converting");

  a_idle_hold: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_12
    !enabled && !result_load
    |=> $stable(shreg_q) && $stable(state_q))
    else $error("word moved while disabled");

  a_msb_first: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_13
    s_read_start
    |=> dout_q == $past(shreg_q[11]))
    else $error("msb not first");

  a_load_restart: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_13
    result_load
    |=> state_q == adcsd_pkg::ADCSD_IDLE && serial_result_pin == $past(clamp_code[11]))
    else $error("new word not presented");

  a_dout_still: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_03
    !step && !result_load
    |=> $stable(dout_q))
    else $error("output moved without a clock fall");

  a_cnt_step: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_03
    step && !result_load && state_q == adcsd_pkg::ADCSD_SHIFT
    |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("bit count did not advance");

  a_cnt_bound: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_13
    state_q != adcsd_pkg::ADCSD_IDLE
    |-> cnt_q != 4'h0 && cnt_q <= 4'(`ADCSD_RES_BITS))
    else $error("bit count out of range");

  a_word_done: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_09
    s_last_bit
    |=> state_q == adcsd_pkg::ADCSD_PASS)
    else $error("word length wrong");

  a_lsb_last: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_13
    s_last_bit
    |=> serial_result_pin == $past(shreg_q[11]))
    else $error("lsb not last");

  a_clamp_high: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_11
    $signed(raw_result) > $signed(13'h07FF)
    |-> clamp_code == `ADCSD_CODE_MAX)
    else $error("over range not full scale");

  a_clamp_low: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_11
    $signed(raw_result) < $signed(13'h1800)
    |-> clamp_code == `ADCSD_CODE_MIN)
    else $error("under range not full scale");

  a_clamp_mid: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_11
    $signed(raw_result) <= $signed(13'h07FF) && $signed(raw_result) >= $signed(13'h1800)
    |-> clamp_code == (raw_result[11:0] ^ 12'h800))
    else $error("in range code folded");

  a_tag_capture: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_07
    s_read_start
    |=> pass_q == $past(tag_ev.level))
    else $error("chain level not captured");

  a_int_pass: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_08
    step && !result_load && !ext_mode && state_q == adcsd_pkg::ADCSD_PASS
    |=> dout_q == $past(pass_q))
    else $error("internal pass-through wrong");

  a_ext_pass: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_14
    step && !result_load && ext_mode && state_q == adcsd_pkg::ADCSD_PASS
    |=> dout_q == $past(shreg_q[11]))
    else $error("chain bit not passed on");

  a_ext_ripple: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_14
    step && !result_load && state_q != adcsd_pkg::ADCSD_IDLE
    |=> shreg_q[0] == $past(tag_ev.level))
    else $error("chain bit not shifted in");
endmodule

// ### rtl/adcsd_regs.svh
// How it works
// RULE_01: Each converter's serial output feeds the next converter's chain input.
// RULE_02: The last converter's serial output drives the host's serial data input.
// RULE_03: In a cascade, bits shift onward on the external shift clock.
// RULE_04: Cascading uses the external shift clock only, never the internal one.
// RULE_05: Host reads all words during acquisition with a gated external clock.
// RULE_06: Acquisition lasts long enough to shift out every word in the chain.
// RULE_07: After a read, serial output equals chain input sampled at read start.
// RULE_08: The chain pass-through works with the external shift clock only, not with the internal one.
// RULE_09: Single converter, internal clock: after 12 bits, output holds the chain input level sampled at read start.
// RULE_10: One separator bit sits between words; grounded first chain input makes it zero. Code adds none: bit 13 is the first captured chain bit.
// RULE_11: Out-of-range inputs give full-scale codes, never wrapping.
// RULE_12: Serial output is enabled only with chip select low and read/convert high.
// RULE_13: External clock: MSB valid from first falling edge, LSB at the twelfth.
// RULE_14: One chain bit captured per clock; first appears at thirteenth falling edge.
// RULE_15: Host must not clock from 12 us after convert start until busy ends.
`ifndef ADCSD_REGS_SVH
`define ADCSD_REGS_SVH
`define ADCSD_RES_BITS      12
`define ADCSD_CODE_MAX      12'hFFF
`define ADCSD_CODE_MIN      12'h000
`define ADCSD_CLK_NS        40
`define ADCSD_INT_PERIOD_NS 840
`define ADCSD_INT_HALF      ((`ADCSD_INT_PERIOD_NS / `ADCSD_CLK_NS) / 2)
`endif

// ### rtl/adcsd_pkg.sv
package adcsd_pkg;
  typedef enum logic [1:0] {
    ADCSD_IDLE,
    ADCSD_SHIFT,
    ADCSD_PASS
  } adcsd_state_t;
endpackage

// ### rtl/adcsd_edge_if.sv
`timescale 1ns/100ps
interface adcsd_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ### rtl/adcsd_sync.sv
`timescale 1ns/100ps
module adcsd_sync (
  input  wire logic clk_sys,   // System clock
  input  wire logic reset,     // Synchronous reset
  input  wire logic pin,       // Asynchronous pin
  adcsd_edge_if.src ev         // Filtered level and edges
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;

  // Level changes once second and third stages agree
  assign lvl_d   = (s2_q == s3_q) ? s3_q : lvl_q;
  assign ev.level = lvl_q;
  assign ev.rise  = lvl_d & ~lvl_q;
  assign ev.fall  = ~lvl_d & lvl_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end
endmodule

// ### bench/adcsd_host_model.sv
`timescale 1ns/100ps
module adcsd_host_model (
  output logic      sck,    // Shift clock, still and low between frames
  input  wire logic sdi,    // Serial line from the last converter
  output logic      chain   // Upstream level into the chain input
);
  initial begin
    sck = 1'b0;
    chain = 1'b0;
  end
  task automatic set_chain(input logic v);
    chain = v;
  endtask
  // Gated frame of n pulses; chain changes mid high phase, far from the fall
  task automatic frame(input int n, input logic [31:0] cb, output logic [31:0] got);
    got = '0;
    // Exactly n falls: the clock rests low after the last one
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      #80;
      chain = cb[i];
      #80;
      sck = 1'b0;
      #156;
      got = {got[30:0], sdi};
      #4;
    end
  endtask
endmodule

// ### bench/adc_serial_daisy_chain_output_tb.sv
`timescale 1ns/100ps
module adc_serial_daisy_chain_output_tb;
  logic        clk_sys, reset, result_load, chip_select_n, read_convert, clock_source_select;
  logic [12:0] raw_result;
  logic        shift_clock_out, shift_clock_oe_n, serial_result_pin, serial_result_oe_n;
  logic        host_sck, chain;
  logic [31:0] got;
  int          errors, n_tests;
  wire logic   shift_pin = shift_clock_oe_n ? host_sck : shift_clock_out;
  // Released line shows the inverse of the last level
  wire logic   sdi_line  = serial_result_oe_n ? ~serial_result_pin : serial_result_pin;

  adcsd_serial_out dut (.clk_sys(clk_sys), .reset(reset), .raw_result(raw_result),
    .result_load(result_load), .chip_select_n(chip_select_n), .read_convert(read_convert),
    .clock_source_select(clock_source_select), .shift_clock_in(shift_pin), .chain_in(chain),
    .shift_clock_out(shift_clock_out), .shift_clock_oe_n(shift_clock_oe_n),
    .serial_result_pin(serial_result_pin), .serial_result_oe_n(serial_result_oe_n));
  adcsd_host_model host (.sck(host_sck), .sdi(sdi_line), .chain(chain));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_oe(input logic lvl);
    int i;
    for (i = 0; i < 20 && serial_result_oe_n !== lvl; i++) @(negedge clk_sys);
    if (i == 20) begin
      errors++;
      summarize();
    end
  endtask
  // Result handed over before each external frame; the second internal-mode load arrives while the internal clock runs, the first before it starts
  task automatic load(input logic [12:0] v);
    @(negedge clk_sys);
    raw_result = v;
    result_load = 1'b1;
    @(negedge clk_sys);
    result_load = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic t_enable;
    repeat (8) @(negedge clk_sys);
    check({30'h0, serial_result_oe_n, shift_clock_oe_n}, 32'h3);
    chip_select_n = 1'b0;
    wait_oe(1'b0);
    read_convert = 1'b0;
    wait_oe(1'b1);
    read_convert = 1'b1;
    wait_oe(1'b0);
    $display("enable gating done");
  endtask
  task automatic ext_word(input logic [12:0] v, input int n, input logic [31:0] cb, input logic [31:0] e);
    load(v);
    host.frame(n, cb, got);
    check(got, e);
    repeat (10) @(negedge clk_sys);
    check({31'h0, serial_result_pin}, {31'h0, e[0]});
    $display("external word %h done", v);
  endtask
  task automatic int_word(input logic lvl);
    int   n_edge;
    logic prev_clk;
    n_edge = 0;
    host.set_chain(lvl);
    load(13'h0000);
    repeat (100) @(negedge clk_sys);
    host.set_chain(~lvl);
    check({31'h0, shift_clock_oe_n}, 32'h0);
    prev_clk = shift_clock_out;
    repeat (60) begin
      @(negedge clk_sys);
      if (shift_clock_out !== prev_clk)
        n_edge++;
      prev_clk = shift_clock_out;
    end
    check((n_edge > 1) ? 32'h1 : 32'h0, 32'h1);
    repeat (160) @(negedge clk_sys);
    check({31'h0, serial_result_pin}, {31'h0, lvl});
    $display("internal word done");
  endtask

  initial begin
    #2000000;
    errors++;
    summarize();
  end
  initial begin
    {result_load, chip_select_n, read_convert, clock_source_select} = 4'b0111;
    raw_result = 13'h0000;
    errors = 0;
    n_tests = 0;
    reset = 1'b1;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    t_enable();
    ext_word(13'h0800, 16, 32'hD, 32'hFFFB);
    ext_word(13'h17FF, 13, 32'h0, 32'h0);
    ext_word(13'h1ABC, 12, 32'h0, 32'h2BC);
    ext_word(13'h0000, 14, 32'hFFFF, 32'h2003);
    @(negedge clk_sys);
    clock_source_select = 1'b0;
    int_word(1'b1);
    int_word(1'b0);
    summarize();
  end
endmodule
